//--- pkg/tpc_pkg.sv
// package: register map, field layout, reset values and states of the pwm block
package tpc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TPC_OFF_CTRL = 8'h00;
  localparam logic [7:0] TPC_OFF_PERIOD = 8'h04;
  localparam logic [7:0] TPC_OFF_COMPARE = 8'h08;
  localparam logic [7:0] TPC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] TPC_OFF_MASK = 8'h10;
  localparam logic [7:0] TPC_OFF_COUNT = 8'h14;
  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int TPC_CTRL_EN = 0;
  localparam int TPC_CTRL_SINGLE = 1;
  localparam int TPC_CTRL_CMPBUF = 2;
  localparam int TPC_CTRL_DBEN = 3;
  localparam int TPC_CTRL_IRQSTYLE = 4;
  localparam int TPC_CTRL_PWM = 5;
  localparam int TPC_CTRL_TYPE_LSB = 8;
  localparam int TPC_CTRL_DB_LSB = 16;
  // ----------------------------------------------------------------
  // status and mask bits
  // ----------------------------------------------------------------
  localparam int TPC_ST_TC = 0;
  localparam int TPC_ST_CMP = 1;
  localparam int TPC_ST_TEN = 2;
  localparam int TPC_ST_TSTOP = 3;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] TPC_RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] TPC_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] TPC_RST_COMPARE = 16'h0000;
  localparam logic [3:0] TPC_RST_MASK = 4'h0;
  localparam logic [1:0] TPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPC_RESP_SLVERR = 2'h2;
  localparam logic [2:0] TPC_CMP_EQ = 3'h0;
  localparam logic [2:0] TPC_CMP_LT = 3'h1;
  localparam logic [2:0] TPC_CMP_LE = 3'h2;
  localparam logic [2:0] TPC_CMP_GT = 3'h3;
  localparam logic [2:0] TPC_CMP_GE = 3'h4;
  typedef enum logic [1:0] {
    TPC_DB_IDLE = 2'h1,
    TPC_DB_WAIT = 2'h2
  } tpc_db_state_t;
endpackage

//--- src/tpc_pwm.sv
// pwm compare block: down counter, compare types, dead band, kill, status
`timescale 1ns/1ps
`default_nettype none
module tpc_pwm
  import tpc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int DB_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic kill,
  input wire logic sleep,
  output logic compare_out,
  output logic tc_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 16 || DB_W < 1 || DB_W > 8) begin : g_chk
    $error("tpc_pwm: CNT_W must be 2..16 and DB_W 1..8");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [CNT_W-1:0] period_reg, compare_reg, cmp_act_reg, count_reg;
  logic [3:0] status_reg, mask_reg, status_next;
  logic aw_rdy_reg, b_vld_reg, ar_rdy_reg, r_vld_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic raw_reg, raw_seen_reg, tc_d_reg, en_d_reg, kill_d_reg;
  logic cmp_st_reg, cpl_st_reg, target_reg;
  logic cmp_out_reg, tc_out_reg, irq_reg;
  logic [DB_W-1:0] db_cnt_reg;
  tpc_db_state_t db_state;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_reg & ~b_vld_reg;
  wire wr_hs = aw_rdy_reg & s_axi_awvalid & s_axi_wvalid;
  wire rd_hs = ar_rdy_reg & s_axi_arvalid;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire wr_ctrl = wr_hs & (s_axi_awaddr == TPC_OFF_CTRL);
  wire wr_per = wr_hs & (s_axi_awaddr == TPC_OFF_PERIOD);
  wire wr_cmp = wr_hs & (s_axi_awaddr == TPC_OFF_COMPARE);
  wire wr_st = wr_hs & (s_axi_awaddr == TPC_OFF_STATUS);
  wire wr_msk = wr_hs & (s_axi_awaddr == TPC_OFF_MASK);
  wire wr_ok = wr_ctrl | wr_per | wr_cmp | wr_st | wr_msk;
  wire [31:0] ctrl_w = (ctrl_reg & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] per_w = (32'(period_reg) & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] cmp_w = (32'(compare_reg) & ~wmask) | (s_axi_wdata & wmask);
  wire [3:0] st_clr = wr_st ? (s_axi_wdata[3:0] & wmask[3:0]) : 4'h0;
  wire rd_map = (s_axi_araddr == TPC_OFF_CTRL)
                | (s_axi_araddr == TPC_OFF_PERIOD)
                | (s_axi_araddr == TPC_OFF_COMPARE)
                | (s_axi_araddr == TPC_OFF_STATUS)
                | (s_axi_araddr == TPC_OFF_MASK)
                | (s_axi_araddr == TPC_OFF_COUNT);
  wire [31:0] rd_mux =
    (s_axi_araddr == TPC_OFF_CTRL) ? ctrl_reg :
    (s_axi_araddr == TPC_OFF_PERIOD) ? 32'(period_reg) :
    (s_axi_araddr == TPC_OFF_COMPARE) ? 32'(compare_reg) :
    (s_axi_araddr == TPC_OFF_STATUS) ? {28'h0000000, status_reg} :
    (s_axi_araddr == TPC_OFF_MASK) ? {28'h0000000, mask_reg} :
    (s_axi_araddr == TPC_OFF_COUNT) ? 32'(count_reg) : 32'h0000_0000;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire en = ctrl_reg[TPC_CTRL_EN];
  wire single_run = ctrl_reg[TPC_CTRL_SINGLE];
  wire compare_value_buffered = ctrl_reg[TPC_CTRL_CMPBUF];
  wire deadband_enable = ctrl_reg[TPC_CTRL_DBEN];
  wire irq_style = ctrl_reg[TPC_CTRL_IRQSTYLE];
  wire mode_pwm = ctrl_reg[TPC_CTRL_PWM];
  wire [2:0] compare_type_select = ctrl_reg[TPC_CTRL_TYPE_LSB +: 3];
  wire [DB_W-1:0] db_len = ctrl_reg[TPC_CTRL_DB_LSB +: DB_W];

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // gated counting
  wire run = en & ~sleep;
  wire en_rise = en & ~en_d_reg;
  wire tc_evt = run & ~en_rise & (count_reg == '0);
  wire stop_evt = tc_evt & single_run;
  wire [CNT_W-1:0] cmp_use = compare_value_buffered ? cmp_act_reg
                                                    : compare_reg;
  wire c_eq = count_reg == cmp_use;
  wire c_lt = count_reg < cmp_use;
  wire c_gt = count_reg > cmp_use;
  wire [CNT_W-1:0] count_next =
    sleep ? '0 :
    en_rise ? period_reg :
    (tc_evt & ~single_run) ? period_reg :
    (run & ~tc_evt) ? count_reg - 1'b1 : count_reg;

  logic raw_next, cmp_evt;
  always_comb begin
    raw_next = raw_reg;
    cmp_evt = 1'b0;
    case (compare_type_select)
      TPC_CMP_EQ: begin
        raw_next = c_eq;
        cmp_evt = c_eq;
      end
      TPC_CMP_LT: begin
        raw_next = c_lt;
        cmp_evt = c_lt;
      end
      TPC_CMP_LE: begin
        raw_next = c_lt | c_eq;
        cmp_evt = c_eq;
      end
      TPC_CMP_GT: begin
        raw_next = c_gt;
        cmp_evt = tc_d_reg;
      end
      TPC_CMP_GE: begin
        raw_next = c_gt | c_eq;
        cmp_evt = tc_d_reg;
      end
      default: begin
        raw_next = 1'b0;
        cmp_evt = 1'b0;
      end
    endcase
    if (!run || !mode_pwm) begin
      // an equality pulse never outlives the run
      raw_next = raw_reg & (compare_type_select != TPC_CMP_EQ);
      cmp_evt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // dead band and kill
  // ----------------------------------------------------------------
  wire db_on = mode_pwm & deadband_enable;
  wire force_low = mode_pwm & (kill | kill_d_reg);
  wire raw_chg = raw_reg != raw_seen_reg;
  wire db_idle = db_state == TPC_DB_IDLE;
  wire db_last = (db_state == TPC_DB_WAIT) & (db_cnt_reg == DB_W'(1));
  wire cmp_o_next = ~force_low & (db_on ? cmp_st_reg : raw_reg);
  wire tc_o_next = ~force_low & (db_on ? cpl_st_reg : tc_evt);

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  wire [3:0] evt = {stop_evt, en_rise, cmp_evt, tc_evt};
  assign status_next = (status_reg & ~st_clr) | evt;
  wire irq_next = irq_style ? |(status_next & mask_reg)
                            : |(evt & mask_reg);

  // ----------------------------------------------------------------
  // bus and register flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_rdy_reg <= 1'b0;
      b_vld_reg <= 1'b0;
      bresp_reg <= TPC_RESP_OKAY;
      ar_rdy_reg <= 1'b0;
      r_vld_reg <= 1'b0;
      rresp_reg <= TPC_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_rdy_reg <= wr_go;
      if (wr_hs) begin
        b_vld_reg <= 1'b1;
        bresp_reg <= wr_ok ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        b_vld_reg <= 1'b0;
      end
      ar_rdy_reg <= s_axi_arvalid & ~ar_rdy_reg & ~r_vld_reg;
      if (rd_hs) begin
        r_vld_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_map ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        r_vld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= TPC_RST_CTRL;
      period_reg <= CNT_W'(TPC_RST_PERIOD);
      compare_reg <= CNT_W'(TPC_RST_COMPARE);
      mask_reg <= TPC_RST_MASK;
      status_reg <= 4'h0;
    end else begin
      // software write wins over the single-run clear of enable
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_w;
      end else if (stop_evt) begin
        ctrl_reg[TPC_CTRL_EN] <= 1'b0;
      end
      if (wr_per) begin
        period_reg <= per_w[CNT_W-1:0];
      end
      if (wr_cmp) begin
        compare_reg <= cmp_w[CNT_W-1:0];
      end
      if (wr_msk) begin
        mask_reg <= s_axi_wdata[3:0];
      end
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // counting and compare flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      cmp_act_reg <= '0;
      raw_reg <= 1'b0;
      tc_d_reg <= 1'b0;
      en_d_reg <= 1'b0;
      kill_d_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      // take new value at period end
      if (tc_evt || en_rise) begin
        cmp_act_reg <= compare_reg;
      end
      raw_reg <= raw_next;
      tc_d_reg <= tc_evt & ~single_run;
      en_d_reg <= en;
      kill_d_reg <= kill;
    end
  end

  // dead band sequencer; a change seen while waiting is dropped, so
  // the output may stay at odds with the compare until it moves again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      db_state <= TPC_DB_IDLE;
      db_cnt_reg <= '0;
      raw_seen_reg <= 1'b0;
      target_reg <= 1'b0;
      cmp_st_reg <= 1'b0;
      cpl_st_reg <= 1'b0;
    end else begin
      raw_seen_reg <= raw_reg;
      case (db_state)
        TPC_DB_IDLE: begin
          if (raw_chg && !force_low) begin
            if (db_len == '0) begin
              cmp_st_reg <= raw_reg;
              cpl_st_reg <= ~raw_reg;
            end else begin
              cmp_st_reg <= 1'b0;
              cpl_st_reg <= 1'b0;
              target_reg <= raw_reg;
              db_cnt_reg <= db_len;
              db_state <= TPC_DB_WAIT;
            end
          end
        end
        TPC_DB_WAIT: begin
          db_cnt_reg <= db_cnt_reg - 1'b1;
          if (db_last) begin
            cmp_st_reg <= target_reg;
            cpl_st_reg <= ~target_reg;
            db_state <= TPC_DB_IDLE;
          end
        end
        default: begin
          db_state <= TPC_DB_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp_out_reg <= 1'b0;
      tc_out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      cmp_out_reg <= cmp_o_next;
      tc_out_reg <= tc_o_next;
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = aw_rdy_reg;
  assign s_axi_bvalid = b_vld_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = r_vld_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign compare_out = cmp_out_reg;
  assign tc_out = tc_out_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_tc_reload: assert property (
    tc_evt && !single_run && !sleep |=> count_reg == $past(period_reg))
    else $error("period not reloaded at terminal count");
  a_count_dec: assert property (
    run && !en_rise && count_reg != '0 |=> count_reg == $past(count_reg) - 1)
    else $error("count did not decrement");
  a_eq_pulse: assert property (
    run && mode_pwm && compare_type_select == TPC_CMP_EQ && c_eq
    |=> raw_reg ##1 !raw_reg)
    else $error("equality pulse wrong");
  a_lt_high: assert property (
    run && mode_pwm && compare_type_select == TPC_CMP_LT && c_lt |=> raw_reg)
    else $error("below compare not high");
  a_off_hold: assert property (
    !run |=> raw_reg == ($past(raw_reg)
                         && $past(compare_type_select) != TPC_CMP_EQ))
    else $error("compare changed while disabled");
  a_buf_hold: assert property (
    compare_value_buffered && !tc_evt && !en_rise |=> $stable(cmp_act_reg))
    else $error("buffered compare changed mid period");
  a_db_wait_low: assert property (
    db_state == TPC_DB_WAIT |-> !cmp_st_reg && !cpl_st_reg)
    else $error("output high during dead band");
  a_db_zero: assert property (
    db_idle && raw_chg && !force_low && db_len == '0
    |=> cmp_st_reg == $past(raw_reg) && cpl_st_reg == !$past(raw_reg))
    else $error("zero dead band delayed");
  a_kill_low: assert property (
    mode_pwm && kill |=> !compare_out && !tc_out)
    else $error("kill did not force outputs low");
  a_kill_lat: assert property (
    mode_pwm && kill ##1 !kill |=> !compare_out && !tc_out)
    else $error("restore came too early");
  a_single_stop: assert property (
    stop_evt && !wr_ctrl |=> !en ##1 count_reg == $past(count_reg))
    else $error("single run did not stop");
  a_sticky: assert property (
    !wr_st |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("status bit lost without clear");
  a_raw_irq: assert property (
    !irq_style && |(evt & mask_reg) |=> irq)
    else $error("raw interrupt pulse missing");
  a_lvl_irq: assert property (
    irq_style && |(status_reg & mask_reg) && !wr_st |=> irq)
    else $error("level interrupt dropped");

  c_kill: cover property (mode_pwm && kill ##1 !kill ##2 compare_out);
  c_db: cover property (db_state == TPC_DB_WAIT ##[1:20] db_last);
  c_stop: cover property (stop_evt);
  c_irq: cover property (irq_style && irq);
endmodule // tpc_pwm
`default_nettype wire

//--- tb/tpc_pins_model.sv
// pin-side partner: kill source and watcher of the pwm outputs
`timescale 1ns/1ps
`default_nettype none
module tpc_pins_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // requests from the bench
  input wire logic kill_req,
  input wire logic clr,
  // pins
  output logic kill,
  input wire logic compare_out,
  input wire logic tc_out,
  input wire logic irq,
  // high-cycle counts since clr
  output var int n_cmp,
  output var int n_tc,
  output var int n_irq,
  output var int n_both
);
  logic held;
  // kill held long
  // a short request is stretched so the block always sees a full cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kill <= 1'b0;
      held <= 1'b0;
    end else begin
      kill <= kill_req || (kill && !held);
      held <= kill;
    end
  end
  always @(posedge clk) begin
    if (clr) begin
      n_cmp <= 0;
      n_tc <= 0;
      n_irq <= 0;
      n_both <= 0;
    end else begin
      n_cmp <= n_cmp + int'(compare_out);
      n_tc <= n_tc + int'(tc_out);
      n_irq <= n_irq + int'(irq);
      n_both <= n_both + int'(compare_out && tc_out);
    end
  end
endmodule // tpc_pins_model
`default_nettype wire

//--- tb/timer_pwm_compare_deadband_tb_top.sv
// testbench: axi4-lite master, register model and pwm pin scenarios
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_compare_deadband_tb_top;
  import tpc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic kill;
  logic sleep = 1'b0;
  logic compare_out;
  logic tc_out;
  logic irq;
  logic kill_req = 1'b0;
  logic clr = 1'b0;
  int n_cmp, n_tc, n_irq, n_both;
  int seed, t, c, l, b, k, ew;
  int cyc = 0;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] d, d2;
  logic [1:0] r;
  logic [31:0] model [0:4];

  always #5 clk = ~clk;

  tpc_pwm u_dut (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .kill(kill), .sleep(sleep),
    .compare_out(compare_out), .tc_out(tc_out), .irq(irq)
  );

  tpc_pins_model u_pins (
    .clk(clk), .resetn(resetn), .kill_req(kill_req), .clr(clr),
    .kill(kill), .compare_out(compare_out), .tc_out(tc_out), .irq(irq),
    .n_cmp(n_cmp), .n_tc(n_tc), .n_irq(n_irq), .n_both(n_both)
  );

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] cw(input logic [2:0] ty,
                                     input logic [5:0] fl,
                                     input logic [7:0] len);
    cw = 32'h0;
    cw[5:0] = fl;
    cw[TPC_CTRL_TYPE_LSB +: 3] = ty;
    cw[TPC_CTRL_DB_LSB +: 8] = len;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    // the model keeps what software wrote; status is write-one-to-clear
    if (a == TPC_OFF_CTRL) model[0] = v;
    if (a == TPC_OFF_PERIOD || a == TPC_OFF_COMPARE) begin
      model[a[4:2]] = {16'h0, v[15:0]};
    end
    if (a == TPC_OFF_MASK) model[4] = {28'h0, v[3:0]};
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    rd(a);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic start(input int p, input int cv, input logic [31:0] ctl,
                       input logic [3:0] m);
    wr(TPC_OFF_CTRL, 32'h0, TPC_RESP_OKAY);
    wr(TPC_OFF_PERIOD, 32'(p), TPC_RESP_OKAY);
    wr(TPC_OFF_COMPARE, 32'(cv), TPC_RESP_OKAY);
    wr(TPC_OFF_MASK, {28'h0, m}, TPC_RESP_OKAY);
    wr(TPC_OFF_STATUS, 32'hF, TPC_RESP_OKAY);
    wr(TPC_OFF_CTRL, ctl, TPC_RESP_OKAY);
    repeat (42) @(posedge clk);
  endtask

  // counts high cycles of each pin over n cycles
  task automatic meas(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 23349;
    model[0] = TPC_RST_CTRL;
    model[1] = {16'h0, TPC_RST_PERIOD};
    model[2] = {16'h0, TPC_RST_COMPARE};
    model[3] = 32'h0;
    model[4] = {28'h0, TPC_RST_MASK};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (k = 0; k < 5; k++) rchk(8'(k * 4), model[k], TPC_RESP_OKAY);
    rchk(TPC_OFF_COUNT, 32'h0, TPC_RESP_OKAY);
    rchk(8'h18, 32'h0, TPC_RESP_SLVERR);
    wr(TPC_OFF_COUNT, 32'h5, TPC_RESP_SLVERR);
    // every compare type, random compare value, period 20
    for (t = 0; t < 5; t++) begin
      c = 2 + int'($unsigned($random(seed)) % 16);
      start(20, c, cw(3'(t), 6'h21, 8'h00), 4'h2);
      meas(21);
      case (t)
        0: ew = 1;
        1: ew = c;
        2: ew = c + 1;
        3: ew = 20 - c;
        default: ew = 21 - c;
      endcase
      chk(32'(n_cmp), 32'(ew));
      chk(32'(n_tc), 32'h1);
      chk(32'(n_irq), 32'(t == 1 ? c : 1));
    end
    // compare value rewritten just after a match
    for (b = 0; b < 2; b++) begin
      start(20, 15, cw(TPC_CMP_EQ, b ? 6'h25 : 6'h21, 8'h00), 4'h0);
      k = 0;
      while (compare_out !== 1'b1 && k < 100) begin
        @(posedge clk);
        k++;
      end
      chk(32'(k < 100), 32'h1);
      wr(TPC_OFF_COMPARE, 32'h3, TPC_RESP_OKAY);
      meas(12);
      chk(32'(n_cmp), 32'(b ? 0 : 1));
    end
    // dead band of zero and of three cycles
    for (l = 0; l < 4; l += 3) begin
      start(20, 8, cw(TPC_CMP_LE, 6'h29, 8'(l)), 4'h0);
      meas(21);
      chk(32'(n_cmp), 32'(9 - l));
      chk(32'(n_tc), 32'(12 - l));
      chk(32'(n_both), 32'h0);
    end
    // kill while complementary outputs run
    start(20, 8, cw(TPC_CMP_GE, 6'h29, 8'h00), 4'h0);
    kill_req <= 1'b1;
    repeat (4) @(posedge clk);
    meas(20);
    chk(32'(n_cmp + n_tc), 32'h0);
    @(posedge clk);
    kill_req <= 1'b0;
    // the restored state only follows the compare again at its next change
    repeat (27) @(posedge clk);
    meas(21);
    chk(32'(n_cmp), 32'd13);
    chk(32'(n_tc), 32'd8);
    // level-style interrupt held until software clears it
    start(20, 8, cw(TPC_CMP_EQ, 6'h31, 8'h00), 4'h1);
    wr(TPC_OFF_CTRL, cw(TPC_CMP_EQ, 6'h30, 8'h00), TPC_RESP_OKAY);
    meas(10);
    chk(32'(n_irq), 32'd10);
    wr(TPC_OFF_STATUS, 32'h1, TPC_RESP_OKAY);
    repeat (2) @(posedge clk);
    meas(20);
    chk(32'(n_irq), 32'h0);
    // single run stops at terminal count and clears enable
    start(10, 5, cw(TPC_CMP_EQ, 6'h23, 8'h00), 4'h8);
    rchk(TPC_OFF_CTRL, 32'h0000_0022, TPC_RESP_OKAY);
    rd(TPC_OFF_STATUS);
    chk(d & 32'h9, 32'h9);
    rd(TPC_OFF_COUNT);
    d2 = d;
    repeat (5) @(posedge clk);
    rchk(TPC_OFF_COUNT, d2, TPC_RESP_OKAY);
    wr(TPC_OFF_STATUS, 32'hF, TPC_RESP_OKAY);
    rchk(TPC_OFF_STATUS, 32'h0, TPC_RESP_OKAY);
    // sleep drops the count and keeps the settings
    start(20, 8, cw(TPC_CMP_EQ, 6'h21, 8'h00), 4'h0);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(TPC_OFF_COUNT, 32'h0, TPC_RESP_OKAY);
    for (k = 0; k < 5; k++) begin
      if (k != 3) rchk(8'(k * 4), model[k], TPC_RESP_OKAY);
    end
    @(posedge clk);
    sleep <= 1'b0;
    give_verdict();
  end
endmodule // timer_pwm_compare_deadband_tb_top
`default_nettype wire
